//--- pkg/rpt_pkg.sv
package rpt_pkg;
   // Register map, byte wide data
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h01;
   localparam logic [4:0] OFF_IRQ_EN = 5'h02;
   localparam logic [4:0] OFF_FLAGS = 5'h03;
   localparam logic [4:0] OFF_SRC = 5'h07;
   localparam logic [4:0] OFF_COUNT_LO = 5'h08;
   localparam logic [4:0] OFF_COUNT_HI = 5'h09;
   localparam logic [4:0] OFF_TOP_LO = 5'h0A;
   localparam logic [4:0] OFF_TOP_HI = 5'h0B;
   localparam logic [4:0] OFF_MATCH_LO = 5'h0C;
   localparam logic [4:0] OFF_MATCH_HI = 5'h0D;
   localparam logic [4:0] OFF_PIT_CTRL = 5'h10;
   localparam logic [4:0] OFF_PIT_STATUS = 5'h11;
   localparam logic [4:0] OFF_PIT_IRQ_EN = 5'h12;
   localparam logic [4:0] OFF_PIT_FLAGS = 5'h13;
   // Field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_PRESC_LSB = 3;
   localparam int CTRL_KEEP_BIT = 7;
   localparam int FLAG_WRAP_BIT = 0;
   localparam int FLAG_MATCH_BIT = 1;
   localparam int PIT_EN_BIT = 0;
   localparam int PIT_PER_LSB = 3;
   // Reset values
   localparam logic [15:0] TOP_RESET = 16'hFFFF;
   localparam logic [15:0] MATCH_RESET = 16'h0000;
   // Timing counts and prescaler bit positions; SYNC_TICKS in timebase ticks
   localparam logic [1:0] SYNC_TICKS = 2'h2;
   localparam logic [4:0] ULP_DIV_LAST = 5'h1F;
   localparam int PRESC_W = 15;
   localparam int TAP_FIRST = 5;
   localparam int TAP_COUNT = 8;
   localparam logic [3:0] PIT_PER_MIN = 4'h1;
   localparam logic [3:0] PIT_PER_MAX = 4'hE;
   typedef enum logic [1:0] {
      SRC_ULP = 2'b00,
      SRC_ULP_DIV32 = 2'b01,
      SRC_CRYSTAL = 2'b10,
      SRC_EXT_CLOCK = 2'b11
   } rpt_src_t;
endpackage : rpt_pkg

//--- hdl/rpt_sync.sv
`timescale 1ns/1ps
module rpt_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } rpt_sync_state_t;
   rpt_sync_state_t s;
   rpt_sync_state_t next_s;
   generate
      if (W < 1) begin : g_bad_width
         $error("rpt_sync width must be positive");
      end
   endgenerate
   always_comb begin
      next_s = s;
      next_s.stage1 = d;
      next_s.stage2 = s.stage1;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign q = s.stage2;
endmodule : rpt_sync

//--- hdl/rpt_prescaler.sv
`timescale 1ns/1ps
module rpt_prescaler #(
   parameter int W = 15
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic step,
   output logic [W-1:0] count
);
   typedef struct packed {
      logic [W-1:0] count;
   } rpt_presc_state_t;
   rpt_presc_state_t s;
   rpt_presc_state_t next_s;
   generate
      if (W < 15) begin : g_bad_width
         $error("rpt_prescaler needs at least 15 bits");
      end
   endgenerate
   // Holds its value while halted
   always_comb begin
      next_s = s;
      if (run && step) begin
         next_s.count = s.count + {{(W-1){1'b0}}, 1'b1};
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign count = s.count;
endmodule : rpt_prescaler

//--- hdl/rpt_top.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// R1 - 16-bit counter steps per prescaled tick, compares
// R2 - Match flag/event on tick after equality
// R3 - Wrap flag/event, counter to zero after top
// R4 - 15-bit prescaler divides selected timebase
// R5 - Timebase: crystal, external, ULP, ULP/32
// R6 - Periodic interval 4 to 32768 timebase periods
// R7 - Eight level tap events, div 64..8192
// R8 - Periodic timer independent of counter enable
// R9 - Counter run bit starts and stops counter
// R10 - Periodic enable bit starts, stops periodic timer
// R11 - Both functions share one prescaler counter
// R12 - Prescaler halts only when both disabled
// R13 - Periodic output toggles every half period
// R14 - Events fire exactly with their flags
// R15 - Bus clock at least 4x timebase
// R16 - Software selects source before enabling
// R17 - Counter setup order ends with run bit
// R18 - Periodic setup order ends with enable
// R19 - Software checks busy bits before configuring
// R20 - Counter interrupts can wake the device
// R21 - Counter runs in standby only if kept
// R22 - Periodic timer runs in every sleep
// R23 - Prescaler change lands two timebase ticks later
// R24 - Interrupt held while enabled and flag set
// R25 - Events last one timebase period
module rpt_top
   import rpt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [rpt_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [rpt_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [rpt_pkg::DATA_W-1:0] reg_rdata,
   input wire logic crystal_pin_one,
   input wire logic crystal_pin_two,
   input wire logic ultra_low_power_osc,
   input wire logic sleep_standby,
   output logic counter_irq,
   output logic periodic_irq,
   output logic wrap_event,
   output logic match_event,
   output logic [rpt_pkg::TAP_COUNT-1:0] tick_tap_event
);
   import rpt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic keep_alive_in_standby;
      logic [3:0] presc_sel;
      logic counter_run_enable;
      logic [3:0] presc_eff;
      logic [1:0] ctrl_busy;
      logic [1:0] irq_en;
      logic [1:0] flags;
      rpt_src_t timebase_source_select;
      logic [15:0] count;
      logic [15:0] top_val;
      logic [15:0] match_val;
      logic [3:0] pit_period;
      logic periodic_tick_enable;
      logic [1:0] pit_busy;
      logic periodic_irq_enable;
      logic pit_flag;
      logic pit_prev;
      logic [4:0] ulp_div;
      logic ulp_prev;
      logic xt1_prev;
      logic xt2_prev;
      logic wrap_ev;
      logic match_ev;
      logic [7:0] rdata;
   } rpt_top_state_t;

   rpt_top_state_t s;
   rpt_top_state_t next_s;
   logic [2:0] pins_sync;
   logic [PRESC_W-1:0] presc_count;
   logic ulp_rise;
   logic xt1_rise;
   logic xt2_rise;
   logic tb_tick;
   logic [PRESC_W-1:0] presc_mask;
   logic counter_awake;
   logic cnt_tick;
   logic hit_top;
   logic hit_match;
   logic pit_valid;
   logic pit_lvl;
   logic presc_run;

   ////////////////////////////////////////////////////////////////////////
   // Pins from the oscillators cross into sys_clk here
   rpt_sync #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({ultra_low_power_osc, crystal_pin_two, crystal_pin_one}),
      .q(pins_sync)
   );

   assign presc_run = s.counter_run_enable | s.periodic_tick_enable; // R12

   // Single shared counter for both functions
   rpt_prescaler #(
      .W(PRESC_W)
   ) u_presc ( // R4 R11
      .sys_clk(sys_clk),
      .rst(rst),
      .run(presc_run),
      .step(tb_tick),
      .count(presc_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // Timebase tick selection
   assign xt1_rise = pins_sync[0] & ~s.xt1_prev;
   assign xt2_rise = pins_sync[1] & ~s.xt2_prev;
   assign ulp_rise = pins_sync[2] & ~s.ulp_prev;

   always_comb begin
      unique case (s.timebase_source_select) // R5
         SRC_ULP: tb_tick = ulp_rise;
         SRC_ULP_DIV32: tb_tick = ulp_rise && (s.ulp_div == ULP_DIV_LAST);
         SRC_CRYSTAL: tb_tick = xt2_rise;
         SRC_EXT_CLOCK: tb_tick = xt1_rise;
      endcase
   end

   // Low presc_eff bits all ones marks a prescaled tick
   assign presc_mask = ~({PRESC_W{1'b1}} << s.presc_eff);
   assign counter_awake = !sleep_standby || s.keep_alive_in_standby; // R21
   assign cnt_tick = tb_tick && s.counter_run_enable && counter_awake &&
      ((presc_count & presc_mask) == presc_mask); // R9
   assign hit_top = (s.count == s.top_val); // R1
   assign hit_match = (s.count == s.match_val); // R1

   // Periodic level is a prescaler bit: toggles each half period
   assign pit_valid = (s.pit_period >= PIT_PER_MIN) &&
      (s.pit_period <= PIT_PER_MAX);
   assign pit_lvl = s.periodic_tick_enable && pit_valid &&
      presc_count[s.pit_period]; // R6 R8 R10 R13 R22

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      next_s.rdata = '0;
      next_s.ulp_prev = pins_sync[2];
      next_s.xt1_prev = pins_sync[0];
      next_s.xt2_prev = pins_sync[1];
      if (ulp_rise) begin
         next_s.ulp_div = s.ulp_div + 5'h01;
      end

      // Busy counts drain on timebase ticks
      if (tb_tick && s.ctrl_busy != 2'h0) begin
         next_s.ctrl_busy = s.ctrl_busy - 2'h1;
         if (s.ctrl_busy == 2'h1) begin
            next_s.presc_eff = s.presc_sel; // R23
         end
      end
      if (tb_tick && s.pit_busy != 2'h0) begin
         next_s.pit_busy = s.pit_busy - 2'h1;
      end

      // Configuration writes
      if (reg_wr) begin
         unique case (reg_addr)
            OFF_CTRL: begin
               next_s.keep_alive_in_standby = reg_wdata[CTRL_KEEP_BIT];
               next_s.presc_sel = reg_wdata[CTRL_PRESC_LSB +: 4];
               next_s.counter_run_enable = reg_wdata[CTRL_RUN_BIT]; // R9
               next_s.ctrl_busy = SYNC_TICKS;
            end
            OFF_IRQ_EN: next_s.irq_en = reg_wdata[1:0];
            OFF_FLAGS: next_s.flags = s.flags & ~reg_wdata[1:0];
            OFF_SRC: begin
               next_s.timebase_source_select = rpt_src_t'(reg_wdata[1:0]);
            end
            OFF_TOP_LO: next_s.top_val[7:0] = reg_wdata;
            OFF_TOP_HI: next_s.top_val[15:8] = reg_wdata;
            OFF_MATCH_LO: next_s.match_val[7:0] = reg_wdata;
            OFF_MATCH_HI: next_s.match_val[15:8] = reg_wdata;
            OFF_PIT_CTRL: begin
               next_s.pit_period = reg_wdata[PIT_PER_LSB +: 4];
               next_s.periodic_tick_enable = reg_wdata[PIT_EN_BIT]; // R10
               next_s.pit_busy = SYNC_TICKS;
            end
            OFF_PIT_IRQ_EN: next_s.periodic_irq_enable = reg_wdata[0];
            OFF_PIT_FLAGS: begin
               if (reg_wdata[0]) begin
                  next_s.pit_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Events end after one timebase period
      if (tb_tick) begin
         next_s.wrap_ev = 1'b0; // R25
         next_s.match_ev = 1'b0; // R25
      end

      // Counter step; flag sets beat clears in the same cycle
      if (cnt_tick) begin
         if (hit_top) begin
            next_s.count = '0; // R3
            next_s.flags[FLAG_WRAP_BIT] = 1'b1; // R3
            next_s.wrap_ev = 1'b1; // R14
         end else begin
            next_s.count = s.count + 16'h0001; // R1
         end
         if (hit_match) begin
            next_s.flags[FLAG_MATCH_BIT] = 1'b1; // R2
            next_s.match_ev = 1'b1; // R14
         end
      end

      next_s.pit_prev = pit_lvl;
      if (pit_lvl && !s.pit_prev) begin
         next_s.pit_flag = 1'b1; // R6
      end

      // Software count write overrides a step
      if (reg_wr && reg_addr == OFF_COUNT_LO) begin
         next_s.count[7:0] = reg_wdata;
      end
      if (reg_wr && reg_addr == OFF_COUNT_HI) begin
         next_s.count[15:8] = reg_wdata;
      end

      if (reg_rd) begin
         unique case (reg_addr)
            OFF_CTRL: next_s.rdata = {s.keep_alive_in_standby,
               s.presc_sel, 2'b00, s.counter_run_enable};
            OFF_STATUS: next_s.rdata = {7'h00, s.ctrl_busy != 2'h0}; // R19
            OFF_IRQ_EN: next_s.rdata = {6'h00, s.irq_en};
            OFF_FLAGS: next_s.rdata = {6'h00, s.flags};
            OFF_SRC: next_s.rdata = {6'h00, s.timebase_source_select};
            OFF_COUNT_LO: next_s.rdata = s.count[7:0];
            OFF_COUNT_HI: next_s.rdata = s.count[15:8];
            OFF_TOP_LO: next_s.rdata = s.top_val[7:0];
            OFF_TOP_HI: next_s.rdata = s.top_val[15:8];
            OFF_MATCH_LO: next_s.rdata = s.match_val[7:0];
            OFF_MATCH_HI: next_s.rdata = s.match_val[15:8];
            OFF_PIT_CTRL: next_s.rdata = {1'b0, s.pit_period, 2'b00,
               s.periodic_tick_enable};
            OFF_PIT_STATUS: next_s.rdata = {7'h00, s.pit_busy != 2'h0};
            OFF_PIT_IRQ_EN: next_s.rdata = {7'h00, s.periodic_irq_enable};
            OFF_PIT_FLAGS: next_s.rdata = {7'h00, s.pit_flag};
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.top_val <= TOP_RESET;
         s.match_val <= MATCH_RESET;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; counter_irq doubles as the wake request
   assign counter_irq = |(s.flags & s.irq_en); // R20 R24
   assign periodic_irq = s.pit_flag && s.periodic_irq_enable; // R24
   assign wrap_event = s.wrap_ev;
   assign match_event = s.match_ev;
   assign reg_rdata = s.rdata;

   genvar gi;
   generate
      for (gi = 0; gi < TAP_COUNT; gi++) begin : g_tap
         assign tick_tap_event[gi] = presc_count[TAP_FIRST + gi]; // R7
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_count_step;
      cnt_tick && !hit_top && !reg_wr |=> s.count == $past(s.count) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) // R1
      else $error("Counter did not step by one");

   property p_wrap;
      cnt_tick && hit_top && !reg_wr |=>
         s.count == 16'h0000 && s.flags[FLAG_WRAP_BIT] && wrap_event;
   endproperty
   a_wrap: assert property (p_wrap) // R3
      else $error("Wrap did not clear counter and raise flag");

   property p_match;
      cnt_tick && hit_match |=> s.flags[FLAG_MATCH_BIT] && match_event;
   endproperty
   a_match: assert property (p_match) // R2
      else $error("Match flag or event missing");

   property p_event_flag;
      $rose(wrap_event) |-> $rose(s.flags[FLAG_WRAP_BIT]) ||
         $past(s.flags[FLAG_WRAP_BIT]);
   endproperty
   a_event_flag: assert property (p_event_flag) // R14
      else $error("Wrap event without its flag");

   property p_event_len;
      wrap_event && !tb_tick |=> wrap_event;
   endproperty
   a_event_len: assert property (p_event_len) // R25
      else $error("Wrap event ended before a timebase tick");

   property p_halt;
      !presc_run |=> $stable(presc_count);
   endproperty
   a_halt: assert property (p_halt) // R12
      else $error("Prescaler moved while both functions off");

   property p_presc_delay;
      reg_wr && reg_addr == OFF_CTRL |=>
         $stable(s.presc_eff) && s.ctrl_busy == SYNC_TICKS;
   endproperty
   a_presc_delay: assert property (p_presc_delay) // R23
      else $error("Prescaler setting applied without delay");

   property p_pit_flag;
      pit_lvl && !s.pit_prev |=> s.pit_flag;
   endproperty
   a_pit_flag: assert property (p_pit_flag) // R6
      else $error("Periodic edge did not set flag");

   property p_irq_hold;
      counter_irq && !reg_wr |=> counter_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) // R24
      else $error("Counter interrupt dropped without clear");

   property p_standby;
      sleep_standby && !s.keep_alive_in_standby && !reg_wr |=>
         $stable(s.count);
   endproperty
   a_standby: assert property (p_standby) // R21
      else $error("Counter moved in standby without keep alive");

   property p_run_off;
      !s.counter_run_enable |-> !cnt_tick;
   endproperty
   a_run_off: assert property (p_run_off) // R9
      else $error("Counter ticked while disabled");

   c_wrap: cover property (cnt_tick && hit_top);
   c_match: cover property (cnt_tick && hit_match);
   c_pit: cover property (s.pit_flag && !s.counter_run_enable);
   c_presc: cover property (s.ctrl_busy == 2'h1 && tb_tick);
endmodule : rpt_top

//--- verif/rpt_osc_model.sv
`timescale 1ns/1ps
module rpt_osc_model #(
   parameter int HALF_ULP = 4,
   parameter int HALF_XTAL = 5,
   parameter int HALF_EXT = 6
) (
   input wire logic sys_clk,
   output logic ulp,
   output logic xtal,
   output logic ext
);
   int half[3];
   int n[3];
   logic [2:0] q = 3'h0;
   assign ulp = q[0];
   assign xtal = q[1];
   assign ext = q[2];
   initial begin
      half = '{HALF_ULP, HALF_XTAL, HALF_EXT};
      n = '{0, 0, 0};
   end
   // Free-running sources, each period at least 8 bus clocks
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         n[i] <= (n[i] == half[i] - 1) ? 0 : n[i] + 1;
         if (n[i] == half[i] - 1) begin
            q[i] <= ~q[i];
         end
      end
   end
endmodule : rpt_osc_model

//--- verif/tb_rpt_top.sv
`timescale 1ns/1ps
module tb_rpt_top;
   import rpt_pkg::*;
   typedef struct packed {
      logic wr;
      logic [4:0] a;
      logic [7:0] d;
   } rpt_row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic pin_one;
   logic pin_two;
   logic ulp_osc;
   logic sleep_standby = 1'b0;
   logic counter_irq;
   logic periodic_irq;
   logic wrap_event;
   logic match_event;
   logic [7:0] tick_tap_event;
   logic [7:0] taps;
   logic [3:0] sig;
   logic [3:0] sig_q = 4'h0;
   logic [7:0] d0;
   logic [7:0] d1;
   int cyc = 0;
   int rise_last[4] = '{0, 0, 0, 0};
   int rise_prev[4] = '{0, 0, 0, 0};
   int fall_last[4] = '{0, 0, 0, 0};
   int exp_wrap[4] = '{32, 1024, 40, 48};
   int bad_count = 0;
   int samples_checked = 0;
   rpt_row_t rows[14] = '{
      '{1'b0, OFF_CTRL, 8'h00}, '{1'b0, OFF_STATUS, 8'h00},
      '{1'b0, OFF_TOP_LO, 8'hFF}, '{1'b0, OFF_TOP_HI, 8'hFF},
      '{1'b0, OFF_MATCH_LO, 8'h00}, '{1'b0, OFF_COUNT_LO, 8'h00},
      '{1'b0, 5'h05, 8'h00}, '{1'b1, 5'h0E, 8'h5A},
      '{1'b0, 5'h0E, 8'h00}, '{1'b1, OFF_SRC, 8'h02},
      '{1'b0, OFF_SRC, 8'h02}, '{1'b1, OFF_MATCH_HI, 8'h12},
      '{1'b0, OFF_MATCH_HI, 8'h12}, '{1'b0, OFF_PIT_CTRL, 8'h00}};

   initial forever #12.5 sys_clk = ~sys_clk;

   rpt_top rpt_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .crystal_pin_one(pin_one),
      .crystal_pin_two(pin_two), .ultra_low_power_osc(ulp_osc),
      .sleep_standby(sleep_standby), .counter_irq(counter_irq),
      .periodic_irq(periodic_irq), .wrap_event(wrap_event),
      .match_event(match_event), .tick_tap_event(tick_tap_event));
   rpt_osc_model rpt_osc_model_i (.sys_clk(sys_clk), .ulp(ulp_osc),
      .xtal(pin_two), .ext(pin_one));

   ////////////////////////////////////////////////////////////////////////
   // Edge time stamps of the observed outputs
   assign sig = {tick_tap_event[0], periodic_irq, match_event, wrap_event};
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      sig_q <= sig;
      for (int i = 0; i < 4; i++) begin
         if (sig[i] === 1'b1 && sig_q[i] === 1'b0) begin
            rise_prev[i] <= rise_last[i];
            rise_last[i] <= cyc;
         end
         if (sig[i] === 1'b0 && sig_q[i] === 1'b1) begin
            fall_last[i] <= cyc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic rdchk(input logic [4:0] a, input logic [7:0] e,
         input string what);
      logic [7:0] d;
      rd(a, d);
      chk({8'h00, d}, {8'h00, e}, what);
   endtask : rdchk

   task automatic wait_hi(input int i, input int max);
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         #1;
         k++;
      end while (sig[i] !== 1'b1 && k < max);
      if (k >= max) begin
         bad_count++;
         $display("Error wait %0d expected 1 seen 0", i);
      end
   endtask : wait_hi

   task automatic span(input int i, input int e, input string what);
      chk(16'(rise_last[i] - rise_prev[i]), 16'(e), what);
   endtask : span

   task automatic end_of_test;
      $display("Checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      $display("Error watchdog expected end seen hang");
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rows[k]) begin
         if (rows[k].wr) begin
            wr(rows[k].a, rows[k].d);
         end else begin
            rdchk(rows[k].a, rows[k].d, "table read");
         end
      end
      // Counter: top 3, match 1, no prescaling
      wr(OFF_SRC, 8'h00);
      wr(OFF_MATCH_LO, 8'h01);
      wr(OFF_MATCH_HI, 8'h00);
      wr(OFF_TOP_LO, 8'h03);
      wr(OFF_TOP_HI, 8'h00);
      wr(OFF_IRQ_EN, 8'h03);
      wr(OFF_CTRL, 8'h01);
      rdchk(OFF_STATUS, 8'h01, "status busy");
      repeat (1200) @(posedge sys_clk);
      span(0, 32, "wrap interval");
      span(1, 32, "match interval");
      chk(16'((rise_last[0] - rise_last[1] + 64) % 32), 16'h0010, "match lead");
      chk(16'((fall_last[0] - rise_last[0] + 64) % 32), 16'h0008, "wrap width");
      span(3, 512, "tap period");
      chk(16'((fall_last[3] - rise_last[3] + 1024) % 512), 16'h0100, "tap half");
      rdchk(OFF_STATUS, 8'h00, "status idle");
      rdchk(OFF_FLAGS, 8'h03, "flags set");
      chk({15'h0000, counter_irq}, 16'h0001, "counter irq");
      wait_hi(1, 100);
      wait_hi(0, 100);
      wr(OFF_FLAGS, 8'h03);
      rdchk(OFF_FLAGS, 8'h00, "flags clear");
      wr(OFF_IRQ_EN, 8'h00);
      repeat (40) @(posedge sys_clk);
      chk({15'h0000, counter_irq}, 16'h0000, "irq masked");
      for (int s = 0; s < 4; s++) begin
         wr(OFF_CTRL, 8'h00);
         wr(OFF_SRC, 8'(s));
         wr(OFF_CTRL, 8'h01);
         repeat (exp_wrap[s] * 3 + 100) @(posedge sys_clk);
         span(0, exp_wrap[s], "source wrap interval");
      end
      wr(OFF_SRC, 8'h00);
      wr(OFF_CTRL, 8'h11);
      repeat (700) @(posedge sys_clk);
      span(0, 128, "prescaled wrap");
      // Both functions off: counter and prescaler hold
      wr(OFF_CTRL, 8'h00);
      rd(OFF_COUNT_LO, d0);
      taps = tick_tap_event;
      repeat (600) @(posedge sys_clk);
      rd(OFF_COUNT_LO, d1);
      chk({8'h00, d1}, {8'h00, d0}, "count held");
      chk({8'h00, tick_tap_event}, {8'h00, taps}, "taps held");
      @(posedge sys_clk);
      sleep_standby <= 1'b1;
      wr(OFF_CTRL, 8'h01);
      rd(OFF_COUNT_LO, d0);
      repeat (100) @(posedge sys_clk);
      rd(OFF_COUNT_LO, d1);
      chk({8'h00, d1}, {8'h00, d0}, "standby held");
      wr(OFF_CTRL, 8'h81);
      rd(OFF_COUNT_LO, d0);
      repeat (20) @(posedge sys_clk);
      rd(OFF_COUNT_LO, d1);
      chk({15'h0000, d1 !== d0}, 16'h0001, "standby kept");
      // Periodic timer alone, still in standby
      wr(OFF_CTRL, 8'h00);
      wr(OFF_PIT_IRQ_EN, 8'h01);
      for (int v = 1; v < 4; v++) begin
         wr(OFF_PIT_CTRL, 8'((v << 3) | 1));
         repeat (2) begin
            wait_hi(2, 300);
            wr(OFF_PIT_FLAGS, 8'h01);
         end
         wait_hi(2, 300);
         repeat (5) @(posedge sys_clk);
         chk({15'h0000, periodic_irq}, 16'h0001, "periodic held");
         span(2, 16 << v, "periodic interval");
         wr(OFF_PIT_FLAGS, 8'h01);
      end
      wr(OFF_PIT_CTRL, 8'h01);
      wr(OFF_PIT_FLAGS, 8'h01);
      repeat (300) @(posedge sys_clk);
      chk({15'h0000, periodic_irq}, 16'h0000, "period off");
      wr(OFF_PIT_CTRL, 8'h00);
      // Second reset in mid-run
      wr(OFF_CTRL, 8'h01);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk({4'h0, counter_irq, periodic_irq, wrap_event, match_event,
         tick_tap_event}, 16'h0000, "outputs in reset");
      @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(OFF_TOP_LO, 8'hFF, "top after reset");
      rdchk(OFF_CTRL, 8'h00, "ctrl after reset");
      // Prescaler restarts from zero: taps show its upper bits
      wr(OFF_CTRL, 8'h01);
      wait_hi(3, 600);
      chk({8'h00, tick_tap_event}, 16'h0001, "taps first");
      repeat (300) @(posedge sys_clk);
      wait_hi(3, 600);
      chk({8'h00, tick_tap_event}, 16'h0003, "taps second");
      end_of_test();
   end
endmodule : tb_rpt_top
